// File: flic_controller.sv
// four-level interrupt controller: request flags, gating, priority, vector
// assumes peripherals pulse flag_hw_set on events and the cpu core drives the handshake inputs
//
// What this block does
// RL1: sixteen sources arbitrated with a four-level priority scheme.
// RL2: a request interrupts only when its enable and the global enable are set.
// RL3: software set or clear of any flag except a level-mode external flag acts exactly like hardware.
// RL4: equal-level ties resolved by polling order, index 0 first, 18 last.
// RL5: vector is 0003H plus eight per index; indices 13, 15, 17 unused.
// RL6: each external input selects level or transition activation by its type bit.
// RL7: vectoring clears an external flag only in transition mode.
// RL8: timer a and b overflow flags request and clear on vectoring.
// RL9: uart request is rx-done or tx-done; neither cleared on vectoring.
// RL10: timer c request ors overflow, external and split-mode low overflow; none cleared.
// RL11: timer d request ors overflow, external and split-mode low overflow; none cleared.
// RL12: spi done flag requests and stays set until software clears it.
// RL13: adc conversion flag requests and is not cleared on vectoring.
// RL14: counter-array request ors overflow and six match flags; none cleared.
// RL15: system request ors rtc, brownouts, watchdog, start, stop, optional uart0 tx.
// RL16: uart0 tx feeds the system request only while routing enable is set.
// RL17: system flags set by their events and not cleared on vectoring.
// RL18: keypad flag set on pattern match, persists until software clears it.
// RL19: two-wire flag set on each new bus state, not cleared on vectoring.
// RL20: each source has a high and a low priority bit.
// RL21: pair 11 is highest level, 10 second, 01 third, 00 lowest.
// RL22: only a strictly higher level preempts a handler in progress.
// RL23: flags sampled each cycle, polled next; vectoring blocked by service, instruction, writes.
// RL24: clearing the global enable disables every interrupt.
// RL25: dma request ors completion and two dma timer flags; none cleared.
// RL26: external pins are synchronised before level sampling or edge detection.
`timescale 1ns/100ps
`default_nettype none

module flic_controller (
	input  wire logic                         sys_clk,
	input  wire logic                         sys_rst,
	// external pins and their configuration
	input  wire logic                         ext_irq_pin_a,
	input  wire logic                         ext_irq_pin_b,
	input  wire logic                         ext_irq_pin_c,
	input  wire logic [2:0]                   ext_type_select,
	input  wire logic [2:0]                   ext_active_high,
	// flag events and software access
	input  wire logic [flic_pkg::NUM_FLAGS-1:0] flag_hw_set,
	input  wire logic [flic_pkg::NUM_FLAGS-1:0] sw_flag_set,
	input  wire logic [flic_pkg::NUM_FLAGS-1:0] sw_flag_clr,
	input  wire logic                         timer_c_split_mode,
	input  wire logic                         timer_d_split_mode,
	input  wire logic                         uart0_tx_sysflag_route,
	// enables and priority
	input  wire logic                         global_irq_enable,
	input  wire logic [flic_pkg::NUM_SRC-1:0] src_enable,
	input  wire logic [flic_pkg::NUM_SRC-1:0] prio_high,
	input  wire logic [flic_pkg::NUM_SRC-1:0] prio_low,
	// cpu handshake
	input  wire logic                         cpu_instr_final,
	input  wire logic                         cpu_block_insn,
	input  wire logic                         cpu_reti,
	// outputs
	output logic [flic_pkg::NUM_FLAGS-1:0]    flag_state_r,
	output logic [flic_pkg::NUM_SRC-1:0]      pending_r,
	output logic                              irq_vector_valid_r,
	output logic [flic_pkg::VEC_W-1:0]        irq_vector_addr_r,
	output logic [flic_pkg::SRC_IDX_W-1:0]    irq_source_r,
	output flic_pkg::flic_level_type          irq_level_r,
	output logic [flic_pkg::NUM_LEVELS-1:0]   in_service_r
);

	// ==========================================================
	// winner search: highest level wins, first index wins a tie
	// returns {found, level[1:0], index[4:0]}
	function automatic logic [7:0] flic_pick(
		input logic [18:0] pend,
		input logic [18:0] hi,
		input logic [18:0] lo
	);
		logic       found;
		logic [1:0] best_lvl;
		logic [4:0] best_idx;
		logic [1:0] lvl;
		found    = 1'b0;
		best_lvl = 2'b00;
		best_idx = 5'h00;
		for (int k = 0; k < flic_pkg::NUM_SRC; k++) begin
			lvl = {hi[k], lo[k]}; // [RL20] [RL21]
			if (pend[k] && (!found || lvl > best_lvl)) begin // [RL4]
				found    = 1'b1;
				best_lvl = lvl;
				best_idx = 5'(k);
			end
		end
		flic_pick = {found, best_lvl, best_idx};
	endfunction

	// ==========================================================
	// external inputs
	logic [2:0] ext_pins;
	logic [2:0] ext_level;
	logic [2:0] ext_edge;

	assign ext_pins = {ext_irq_pin_c, ext_irq_pin_b, ext_irq_pin_a};

	generate
		for (genvar e = 0; e < flic_pkg::NUM_EXT; e++) begin : g_ext
			flic_ext_input u_ext (
				.sys_clk      (sys_clk),
				.sys_rst      (sys_rst),
				.pin_in       (ext_pins[e]),
				.active_high  (ext_active_high[e]),
				.level_active (ext_level[e]),
				.edge_pulse   (ext_edge[e])
			);
		end
	endgenerate

	// ==========================================================
	// request flags
	logic [flic_pkg::NUM_FLAGS-1:0] hw_set;
	logic [flic_pkg::NUM_FLAGS-1:0] vec_clr;
	logic [flic_pkg::NUM_FLAGS-1:0] flag_nxt;
	logic [flic_pkg::NUM_FLAGS-1:0] f;

	assign f = flag_state_r;

	// external flag events come from the pin stage, the rest from peripherals
	generate
		for (genvar i = 0; i < flic_pkg::NUM_FLAGS; i++) begin : g_flag
			if (i < flic_pkg::NUM_EXT) begin : g_ext_flag
				assign hw_set[i] = ext_edge[i] & ext_type_select[i]; // [RL6]
				// level mode: the pin alone drives the flag, a software set lasts one cycle and a software clear has no effect
				assign flag_nxt[i] = ext_type_select[i]
					? (hw_set[i] | sw_flag_set[i] | (f[i] & ~(sw_flag_clr[i] | vec_clr[i]))) // [RL3]
					: (ext_level[i] | sw_flag_set[i]); // [RL6] [RL7]
			end else begin : g_per_flag
				assign hw_set[i] = flag_hw_set[i]; // [RL12] [RL17] [RL18] [RL19]
				// a hardware event in the clearing cycle is kept
				assign flag_nxt[i] = hw_set[i] | sw_flag_set[i] | (f[i] & ~(sw_flag_clr[i] | vec_clr[i])); // [RL3]
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			flag_state_r <= '0;
		end else begin
			flag_state_r <= flag_nxt;
		end
	end

	// ==========================================================
	// per-source requests
	logic [flic_pkg::NUM_SRC-1:0] src_req;
	logic                         pca_any;
	logic                         sys_any;

	assign pca_any = |f[flic_pkg::F_PCA_MATCH0 +: flic_pkg::NUM_PCA_MATCH] | f[flic_pkg::F_PCA_OVF]; // [RL14]
	assign sys_any = f[flic_pkg::F_RTC_OVF] | f[flic_pkg::F_BROWNOUT_A] | f[flic_pkg::F_BROWNOUT_B]
		| f[flic_pkg::F_WATCHDOG] | f[flic_pkg::F_SER_START] | f[flic_pkg::F_SER_STOP]
		| (f[flic_pkg::F_U0_TX] & uart0_tx_sysflag_route); // [RL15] [RL16]

	always_comb begin
		src_req = '0;
		src_req[flic_pkg::SRC_EXT0]    = f[flic_pkg::F_EXT0];
		src_req[flic_pkg::SRC_TMRA]    = f[flic_pkg::F_TMRA_OVF]; // [RL8]
		src_req[flic_pkg::SRC_EXT1]    = f[flic_pkg::F_EXT1];
		src_req[flic_pkg::SRC_TMRB]    = f[flic_pkg::F_TMRB_OVF]; // [RL8]
		src_req[flic_pkg::SRC_UART0]   = f[flic_pkg::F_U0_RX] | f[flic_pkg::F_U0_TX]; // [RL9]
		src_req[flic_pkg::SRC_TMRC]    = f[flic_pkg::F_TC_OVF] | f[flic_pkg::F_TC_EXT]
			| (f[flic_pkg::F_TC_LOW] & timer_c_split_mode); // [RL10]
		src_req[flic_pkg::SRC_EXT2]    = f[flic_pkg::F_EXT2];
		src_req[flic_pkg::SRC_SPI]     = f[flic_pkg::F_SPI_DONE]; // [RL12]
		src_req[flic_pkg::SRC_ADC]     = f[flic_pkg::F_ADC_CONV]; // [RL13]
		src_req[flic_pkg::SRC_PCA]     = pca_any;
		src_req[flic_pkg::SRC_SYSFLAG] = sys_any;
		src_req[flic_pkg::SRC_KEYPAD]  = f[flic_pkg::F_KEYPAD]; // [RL18]
		src_req[flic_pkg::SRC_TWI]     = f[flic_pkg::F_TWI]; // [RL19]
		src_req[flic_pkg::SRC_UART1]   = f[flic_pkg::F_U1_RX] | f[flic_pkg::F_U1_TX]; // [RL9]
		src_req[flic_pkg::SRC_TMRD]    = f[flic_pkg::F_TD_OVF] | f[flic_pkg::F_TD_EXT]
			| (f[flic_pkg::F_TD_LOW] & timer_d_split_mode); // [RL11]
		src_req[flic_pkg::SRC_DMA]     = f[flic_pkg::F_DMA_DONE] | f[flic_pkg::F_DMA_TMRA]
			| f[flic_pkg::F_DMA_TMRB]; // [RL25]
	end

	// ==========================================================
	// sample stage: enabled requests are captured every cycle
	logic [flic_pkg::NUM_SRC-1:0] pending_nxt;

	assign pending_nxt = src_req & src_enable & {flic_pkg::NUM_SRC{global_irq_enable}}
		& ~flic_pkg::SRC_RESERVED; // [RL1] [RL2] [RL24] [RL23]

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pending_r <= '0;
		end else begin
			pending_r <= pending_nxt;
		end
	end

	// ==========================================================
	// poll stage: pick a winner from the previous cycle's samples
	logic [7:0]                          pick;
	logic                                win_valid;
	logic [1:0]                          win_lvl;
	logic [flic_pkg::SRC_IDX_W-1:0]      win_idx;
	logic [flic_pkg::NUM_LEVELS-1:0]     at_or_above;
	logic                                svc_block;
	logic                                vec_fire;

	assign pick      = flic_pick(pending_r, prio_high, prio_low);
	assign win_valid = pick[7];
	assign win_lvl   = pick[6:5];
	assign win_idx   = pick[4:0];

	// any handler in progress at this level or above holds the request off
	assign at_or_above = 4'(4'hF << win_lvl);
	assign svc_block   = |(in_service_r & at_or_above); // [RL22]

	// global enable rechecked here so clearing it stops a request already sampled
	assign vec_fire = win_valid & ~svc_block & cpu_instr_final & ~cpu_block_insn
		& ~cpu_reti & global_irq_enable; // [RL23] [RL24]

	// ==========================================================
	// hardware clears on vectoring: timers a/b always, external only in transition mode
	always_comb begin
		vec_clr = '0;
		vec_clr[flic_pkg::F_EXT0]     = vec_fire && win_idx == 5'(flic_pkg::SRC_EXT0) && ext_type_select[0]; // [RL7]
		vec_clr[flic_pkg::F_EXT1]     = vec_fire && win_idx == 5'(flic_pkg::SRC_EXT1) && ext_type_select[1]; // [RL7]
		vec_clr[flic_pkg::F_EXT2]     = vec_fire && win_idx == 5'(flic_pkg::SRC_EXT2) && ext_type_select[2]; // [RL7]
		vec_clr[flic_pkg::F_TMRA_OVF] = vec_fire && win_idx == 5'(flic_pkg::SRC_TMRA); // [RL8]
		vec_clr[flic_pkg::F_TMRB_OVF] = vec_fire && win_idx == 5'(flic_pkg::SRC_TMRB); // [RL8]
	end

	// ==========================================================
	// in-service tracking, one bit per level; return ends the highest one
	logic [flic_pkg::NUM_LEVELS-1:0] reti_mask;
	logic [flic_pkg::NUM_LEVELS-1:0] vec_mask;
	logic [flic_pkg::NUM_LEVELS-1:0] in_service_nxt;
	logic [flic_pkg::VEC_W-1:0]      vec_addr;

	assign reti_mask = !cpu_reti        ? 4'h0 :
	                   in_service_r[3]  ? 4'h8 :
	                   in_service_r[2]  ? 4'h4 :
	                   in_service_r[1]  ? 4'h2 :
	                   in_service_r[0]  ? 4'h1 : 4'h0;
	assign vec_mask  = vec_fire ? 4'(4'h1 << win_lvl) : 4'h0;

	assign in_service_nxt = (in_service_r & ~reti_mask) | vec_mask; // [RL22]

	assign vec_addr = flic_pkg::VEC_BASE
		+ 16'({11'h000, win_idx} << flic_pkg::VEC_STEP_SHIFT); // [RL5]

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			in_service_r       <= flic_pkg::IN_SERVICE_RST;
			irq_vector_valid_r <= 1'b0;
			irq_vector_addr_r  <= flic_pkg::VEC_BASE;
			irq_source_r       <= 5'h00;
			irq_level_r        <= flic_pkg::FLIC_LVL_LOWEST;
		end else begin
			in_service_r       <= in_service_nxt;
			irq_vector_valid_r <= vec_fire;
			if (vec_fire) begin
				irq_vector_addr_r <= vec_addr;
				irq_source_r      <= win_idx;
				irq_level_r       <= flic_pkg::flic_level_type'(win_lvl);
			end
		end
	end

endmodule

`default_nettype wire

// File: flic_controller_props.sv
// port-level checker for the interrupt controller
// assumes a single sys_clk domain; bound onto flic_controller below
`timescale 1ns/100ps
`default_nettype none
module flic_controller_props (
	input wire logic                          sys_clk,
	input wire logic                          sys_rst,
	input wire logic [flic_pkg::NUM_FLAGS-1:0] flag_hw_set,
	input wire logic [flic_pkg::NUM_FLAGS-1:0] sw_flag_set,
	input wire logic [flic_pkg::NUM_FLAGS-1:0] sw_flag_clr,
	input wire logic                          global_irq_enable,
	input wire logic [flic_pkg::NUM_SRC-1:0]  src_enable,
	input wire logic [flic_pkg::NUM_SRC-1:0]  prio_high,
	input wire logic [flic_pkg::NUM_SRC-1:0]  prio_low,
	input wire logic                          cpu_instr_final,
	input wire logic                          cpu_block_insn,
	input wire logic                          cpu_reti,
	input wire logic [flic_pkg::NUM_FLAGS-1:0] flag_state_r,
	input wire logic [flic_pkg::NUM_SRC-1:0]  pending_r,
	input wire logic                          irq_vector_valid_r,
	input wire logic [flic_pkg::VEC_W-1:0]    irq_vector_addr_r,
	input wire logic [flic_pkg::SRC_IDX_W-1:0] irq_source_r,
	input wire flic_pkg::flic_level_type      irq_level_r,
	input wire logic [flic_pkg::NUM_LEVELS-1:0] in_service_r
);
	// ==========================================================
	// decision-edge copies, so a vector is judged against what the arbiter saw
	localparam logic [34:0] NOCLR = 35'h7FFFFFFE0;
	localparam logic [34:0] SWMSK = 35'h7FFFFFFF8;
	logic [18:0] pend_d;
	logic [18:0] ph_d;
	logic [18:0] pl_d;
	logic [3:0]  isr_d;
	logic        better;
	always_ff @(posedge sys_clk) begin
		pend_d <= pending_r;
		ph_d <= prio_high;
		pl_d <= prio_low;
		isr_d <= in_service_r;
	end
	always_comb begin
		better = 1'b0;
		for (int i = 0; i < 19; i++) begin
			if (pend_d[i] && (({ph_d[i], pl_d[i]} > irq_level_r)
			    || ({ph_d[i], pl_d[i]} == irq_level_r && i < int'(irq_source_r))))
				better = 1'b1;
		end
	end
	default clocking dcb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// ==========================================================
	a_vec_addr_map: assert property (irq_vector_valid_r |-> irq_vector_addr_r == 16'h0003 + {irq_source_r, 3'h0}
		&& !flic_pkg::SRC_RESERVED[irq_source_r]) else $error("vector address does not match source");
	a_level_from_pair: assert property (irq_vector_valid_r |-> irq_level_r == {ph_d[irq_source_r], pl_d[irq_source_r]})
		else $error("vector level differs from priority pair");
	a_poll_winner: assert property (irq_vector_valid_r |-> !better) else $error("a better request was passed over");
	a_no_low_preempt: assert property (irq_vector_valid_r |-> (isr_d >> irq_level_r) == 4'h0)
		else $error("vector issued over an equal or higher level in service");
	a_block_vector: assert property ((cpu_block_insn || !cpu_instr_final || cpu_reti) |=> !irq_vector_valid_r)
		else $error("vector issued in a blocked cycle");
	a_global_gate: assert property (!global_irq_enable |=> !irq_vector_valid_r) else $error("vector with global enable low");
	a_enable_gate: assert property (1'b1 |=> (pending_r & ~$past(src_enable)) == 19'h0)
		else $error("disabled source pending");
	a_flags_persist: assert property (irq_vector_valid_r && !$past(|sw_flag_clr) |->
		($past(flag_state_r) & ~flag_state_r & NOCLR) == 35'h0) else $error("vectoring cleared a sticky flag");
	a_timer_autoclr: assert property (irq_vector_valid_r && irq_source_r == 5'h01
		&& !$past(flag_hw_set[3] || sw_flag_set[3]) |-> !flag_state_r[3])
		else $error("timer a flag not cleared on vectoring");
	a_sw_set_flag: assert property ((sw_flag_set & SWMSK) != 35'h0 |=>
		(flag_state_r & $past(sw_flag_set & SWMSK)) == $past(sw_flag_set & SWMSK)) else $error("software set lost");
	a_sw_clr_flag: assert property (1'b1 |=> (flag_state_r & $past(sw_flag_clr & ~sw_flag_set & ~flag_hw_set & SWMSK))
		== 35'h0) else $error("software clear lost");
endmodule
bind flic_controller flic_controller_props i_flic_controller_props (.sys_clk, .sys_rst, .flag_hw_set, .sw_flag_set,
	.sw_flag_clr, .global_irq_enable, .src_enable, .prio_high, .prio_low, .cpu_instr_final, .cpu_block_insn, .cpu_reti,
	.flag_state_r, .pending_r, .irq_vector_valid_r, .irq_vector_addr_r, .irq_source_r, .irq_level_r, .in_service_r);
`default_nettype wire

// File: flic_cpu_model.sv
// behavioural cpu core facing the controller's handshake
// assumes it is clocked by the bench clock and returns from each handler after hold_cycles
`timescale 1ns/100ps
`default_nettype none
module flic_cpu_model (
	input  wire logic       sys_clk,
	input  wire logic       irq_vector_valid_r,
	input  wire logic [3:0] hold_cycles,
	output logic            cpu_instr_final,
	output logic            cpu_block_insn,
	output logic            cpu_reti
);
	int depth = 0;
	int wait_cnt = 0;
	int phase = 0;
	initial begin
		cpu_instr_final = 1'b1;
		cpu_block_insn = 1'b0;
		cpu_reti = 1'b0;
	end
	// ==========================================================
	// a multi-cycle instruction every fourth cycle keeps the final-cycle gate exercised
	always @(negedge sys_clk) begin
		phase = phase + 1;
		cpu_instr_final = (phase % 4) != 0;
		cpu_block_insn = cpu_reti;
		cpu_reti = 1'b0;
		if (irq_vector_valid_r === 1'b1) begin
			depth = depth + 1;
			wait_cnt = 0;
		end else if (depth > 0) begin
			wait_cnt = wait_cnt + 1;
			// nested handlers return innermost first
			if (wait_cnt >= hold_cycles) begin
				cpu_reti = 1'b1;
				depth = depth - 1;
				wait_cnt = 0;
			end
		end
	end
endmodule
`default_nettype wire

// File: flic_ext_input.sv
// one external interrupt pin: synchroniser, polarity and transition detect
// assumes the pin is asynchronous to sys_clk; polarity select is quasi-static
`timescale 1ns/100ps
`default_nettype none

module flic_ext_input (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic pin_in,
	input  wire logic active_high,
	output logic      level_active,
	output logic      edge_pulse
);

	logic sync1_r;
	logic sync2_r;
	logic prev_active_r;

	// ==========================================================
	// synchroniser, the first stage feeds only the second
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			// reset to the idle level, so an active-low level-mode pin does not look asserted after reset
			sync1_r <= ~active_high;
			sync2_r <= ~active_high;
		end else begin
			sync1_r <= pin_in; // [RL26]
			sync2_r <= sync1_r;
		end
	end

	// ==========================================================
	// edge detect; previous state resets active, but the synchroniser resets idle, so a pin held active through reset gives an edge after release
	assign level_active = sync2_r ~^ active_high; // [RL26]

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			prev_active_r <= 1'b1;
		end else begin
			prev_active_r <= level_active;
		end
	end

	assign edge_pulse = level_active & ~prev_active_r;

endmodule

`default_nettype wire

// File: flic_pkg.sv
// constants shared by the four-level interrupt controller, its port checker and its bench
// assumes a single system clock domain; all flag and source indices are fixed here
`default_nettype none

package flic_pkg;

	// ==========================================================
	// flag vector layout (external flags first so a loop can find them)
	localparam int unsigned NUM_EXT          = 3;
	localparam int unsigned F_EXT0           = 0;
	localparam int unsigned F_EXT1           = 1;
	localparam int unsigned F_EXT2           = 2;
	localparam int unsigned F_TMRA_OVF       = 3;
	localparam int unsigned F_TMRB_OVF       = 4;
	localparam int unsigned F_U0_RX          = 5;
	localparam int unsigned F_U0_TX          = 6;
	localparam int unsigned F_U1_RX          = 7;
	localparam int unsigned F_U1_TX          = 8;
	localparam int unsigned F_TC_OVF         = 9;
	localparam int unsigned F_TC_EXT         = 10;
	localparam int unsigned F_TC_LOW         = 11;
	localparam int unsigned F_TD_OVF         = 12;
	localparam int unsigned F_TD_EXT         = 13;
	localparam int unsigned F_TD_LOW         = 14;
	localparam int unsigned F_SPI_DONE       = 15;
	localparam int unsigned F_ADC_CONV       = 16;
	localparam int unsigned F_PCA_OVF        = 17;
	localparam int unsigned F_PCA_MATCH0     = 18;
	localparam int unsigned NUM_PCA_MATCH    = 6;
	localparam int unsigned F_RTC_OVF        = 24;
	localparam int unsigned F_BROWNOUT_A     = 25;
	localparam int unsigned F_BROWNOUT_B     = 26;
	localparam int unsigned F_WATCHDOG       = 27;
	localparam int unsigned F_SER_START      = 28;
	localparam int unsigned F_SER_STOP       = 29;
	localparam int unsigned F_KEYPAD         = 30;
	localparam int unsigned F_TWI            = 31;
	localparam int unsigned F_DMA_DONE       = 32;
	localparam int unsigned F_DMA_TMRA       = 33;
	localparam int unsigned F_DMA_TMRB       = 34;
	localparam int unsigned NUM_FLAGS        = 35;

	// ==========================================================
	// source indices, polling order is index order
	localparam int unsigned NUM_SRC          = 19;
	localparam int unsigned SRC_EXT0         = 0;
	localparam int unsigned SRC_TMRA         = 1;
	localparam int unsigned SRC_EXT1         = 2;
	localparam int unsigned SRC_TMRB         = 3;
	localparam int unsigned SRC_UART0        = 4;
	localparam int unsigned SRC_TMRC         = 5;
	localparam int unsigned SRC_EXT2         = 6;
	localparam int unsigned SRC_SPI          = 7;
	localparam int unsigned SRC_ADC          = 8;
	localparam int unsigned SRC_PCA          = 9;
	localparam int unsigned SRC_SYSFLAG      = 10;
	localparam int unsigned SRC_KEYPAD       = 11;
	localparam int unsigned SRC_TWI          = 12;
	localparam int unsigned SRC_UART1        = 14;
	localparam int unsigned SRC_TMRD         = 16;
	localparam int unsigned SRC_DMA          = 18;
	localparam logic [18:0] SRC_RESERVED     = 19'h2A000;

	// ==========================================================
	// vectors and levels
	localparam int unsigned SRC_IDX_W        = 5;
	localparam int unsigned VEC_W            = 16;
	localparam logic [15:0] VEC_BASE         = 16'h0003;
	localparam int unsigned VEC_STEP_SHIFT   = 3;
	localparam int unsigned NUM_LEVELS       = 4;

	// priority pair {high,low}: 11 is the top level, 00 the bottom
	typedef enum logic [1:0] {
		FLIC_LVL_LOWEST  = 2'b00,
		FLIC_LVL_THIRD   = 2'b01,
		FLIC_LVL_SECOND  = 2'b10,
		FLIC_LVL_HIGHEST = 2'b11
	} flic_level_type;

	localparam logic [3:0]  IN_SERVICE_RST   = 4'h0;

endpackage

`default_nettype wire

// File: tb_flic_controller.sv
// self-checking bench for the interrupt controller
// assumes flic_cpu_model answers vectors; expected vectors are queued as {source, level}
`timescale 1ns/100ps
`default_nettype none
module tb_flic_controller;
	logic        sys_clk = 1'b0, sys_rst = 1'b1;
	logic        ext_irq_pin_a = 1'b1, ext_irq_pin_b = 1'b1, ext_irq_pin_c = 1'b0;
	logic [2:0]  ext_type_select = 3'h5, ext_active_high = 3'h4;
	logic [34:0] flag_hw_set = '0, sw_flag_set = '0, sw_flag_clr = '0, flag_state_r;
	logic        timer_c_split_mode = 1'b0, timer_d_split_mode = 1'b0, uart0_tx_sysflag_route = 1'b0;
	logic        global_irq_enable = 1'b1, cpu_instr_final, cpu_block_insn, cpu_reti, irq_vector_valid_r;
	logic [18:0] src_enable = '1, prio_high = '0, prio_low = '0, pending_r;
	logic [15:0] irq_vector_addr_r;
	logic [4:0]  irq_source_r;
	logic [3:0]  in_service_r, hold_cycles = 4'h4;
	logic [6:0]  notes[$], n;
	logic [31:0] rs = 32'hED0B8386;
	int          bad_count = 0, compares = 0;
	flic_pkg::flic_level_type irq_level_r;
	int          src_t[13] = '{1, 3, 4, 5, 7, 8, 9, 10, 11, 12, 14, 16, 18};
	int          flg_t[13] = '{3, 4, 6, 9, 15, 16, 20, 27, 30, 31, 8, 13, 34};
	always #12.5 sys_clk = ~sys_clk;
	flic_controller i_flic_controller (.sys_clk, .sys_rst, .ext_irq_pin_a, .ext_irq_pin_b, .ext_irq_pin_c,
		.ext_type_select, .ext_active_high, .flag_hw_set, .sw_flag_set, .sw_flag_clr, .timer_c_split_mode,
		.timer_d_split_mode, .uart0_tx_sysflag_route, .global_irq_enable, .src_enable, .prio_high, .prio_low,
		.cpu_instr_final, .cpu_block_insn, .cpu_reti, .flag_state_r, .pending_r, .irq_vector_valid_r,
		.irq_vector_addr_r, .irq_source_r, .irq_level_r, .in_service_r);
	flic_cpu_model i_flic_cpu_model (.sys_clk, .irq_vector_valid_r, .hold_cycles, .cpu_instr_final,
		.cpu_block_insn, .cpu_reti);
	// ==========================================================
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task check(input logic [34:0] seen, input logic [34:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task print_verdict();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// k: 0 hardware event, 1 software set, 2 software clear
	task pulse(input logic [34:0] m, input int k);
		if (k == 0) flag_hw_set = m;
		else if (k == 1) sw_flag_set = m;
		else sw_flag_clr = m;
		@(negedge sys_clk);
		flag_hw_set = '0;
		sw_flag_set = '0;
		sw_flag_clr = '0;
	endtask
	task setp(input int s, input logic [1:0] lv);
		prio_high[s] = lv[1];
		prio_low[s] = lv[0];
	endtask
	task expect_vec(input int s, input logic [1:0] lv);
		notes.push_back({5'(s), lv});
	endtask
	task drain();
		for (int i = 0; i < 80 && notes.size() != 0; i++) @(negedge sys_clk);
		check(notes.size(), 0);
	endtask
	task idle(input int c);
		repeat (c) @(negedge sys_clk);
	endtask
	// ==========================================================
	// vector monitor: every vector must match the oldest note, none may come unasked
	always @(negedge sys_clk) begin
		if (irq_vector_valid_r === 1'b1) begin
			if (notes.size() == 0) check(1, 0);
			else begin
				n = notes.pop_front();
				check(irq_source_r, n[6:2]);
				check(irq_vector_addr_r, 16'h0003 + {n[6:2], 3'h0});
				check(irq_level_r, n[1:0]);
			end
		end
	end
	initial begin
		#(25 * 6000);
		bad_count++;
		print_verdict();
	end
	initial begin
		idle(10);
		sys_rst = 1'b0;
		idle(1);
		check(irq_vector_addr_r, 16'h0003);
		for (int i = 0; i < 13; i++) begin
			rs = xs(rs);
			setp(src_t[i], rs[1:0]);
			expect_vec(src_t[i], rs[1:0]);
			pulse(35'h1 << flg_t[i], int'(rs[2]));
			drain();
			check(flag_state_r[flg_t[i]], src_t[i] > 3 ? 1 : 0);
			pulse(35'h1 << flg_t[i], 2);
			idle(10);
		end
		setp(1, 2'h1);
		setp(3, 2'h1);
		expect_vec(1, 2'h1);
		expect_vec(3, 2'h1);
		pulse(35'h18, 0);
		drain();
		idle(10);
		setp(3, 2'h2);
		expect_vec(3, 2'h2);
		expect_vec(1, 2'h1);
		pulse(35'h18, 1);
		drain();
		idle(10);
		hold_cycles = 4'hF;
		setp(1, 2'h0);
		setp(3, 2'h3);
		expect_vec(1, 2'h0);
		pulse(35'h8, 0);
		drain();
		expect_vec(3, 2'h3);
		pulse(35'h10, 0);
		drain();
		check(in_service_r, 4'h9);
		idle(40);
		expect_vec(3, 2'h3);
		expect_vec(1, 2'h0);
		pulse(35'h18, 0);
		idle(8);
		check(notes.size(), 1);
		drain();
		idle(40);
		hold_cycles = 4'h8;
		global_irq_enable = 1'b0;
		pulse(35'h10, 0);
		idle(8);
		check(pending_r, 0);
		expect_vec(3, 2'h3);
		global_irq_enable = 1'b1;
		drain();
		idle(12);
		src_enable[3] = 1'b0;
		pulse(35'h10, 0);
		idle(8);
		check(pending_r[3], 0);
		expect_vec(3, 2'h3);
		src_enable[3] = 1'b1;
		drain();
		idle(12);
		setp(5, 2'h0);
		pulse(35'h800, 0);
		idle(8);
		check(pending_r[5], 0);
		expect_vec(5, 2'h0);
		timer_c_split_mode = 1'b1;
		drain();
		pulse(35'h800, 2);
		setp(16, 2'h0);
		pulse(35'h4000, 0);
		idle(8);
		check(pending_r[16], 0);
		expect_vec(16, 2'h0);
		timer_d_split_mode = 1'b1;
		drain();
		pulse(35'h4000, 2);
		idle(12);
		src_enable[4] = 1'b0;
		uart0_tx_sysflag_route = 1'b1;
		setp(10, 2'h0);
		expect_vec(10, 2'h0);
		pulse(35'h40, 1);
		drain();
		pulse(35'h40, 2);
		uart0_tx_sysflag_route = 1'b0;
		src_enable[4] = 1'b1;
		idle(12);
		setp(0, 2'h0);
		setp(2, 2'h0);
		setp(6, 2'h0);
		expect_vec(0, 2'h0);
		ext_irq_pin_a = 1'b0;
		idle(1);
		check(flag_state_r[0], 0);
		drain();
		check(flag_state_r[0], 0);
		idle(12);
		expect_vec(2, 2'h0);
		ext_irq_pin_b = 1'b0;
		drain();
		check(flag_state_r[1], 1);
		ext_irq_pin_b = 1'b1;
		idle(5);
		check(flag_state_r[1], 0);
		idle(12);
		expect_vec(6, 2'h0);
		ext_irq_pin_c = 1'b1;
		drain();
		check(flag_state_r[2], 0);
		idle(12);
		print_verdict();
	end
endmodule
`default_nettype wire
